//--- hdl/gripper_mode_sequencer.sv
// Gripper mode sequencer: registers, homing, positioning, gripping
// Operation
// - Mode 3 with command 1 energises motor
// - Home inward to stop, load inner endpoint
// - De-energise after homing; host re-energises
// - Fault code zero once homed and ready
// - Accept only the listed mode codes
// - 0x0100 to outer, 0x0200 to inner
// - Positioning ignores expected location, switch point
// - Obstacle stops; opposite command drives back
// - Mode 51 skips unlocking at start
// - Unlock toward standby, then positioning
// - Approach speed derived from force setpoint
// - Group 70 swaps outer and inner
// - Grip command builds force, engages lock
// - No part: overshoot, reverse, rest at endpoint
// - Open command positions to open endpoint
// - Mode 60 unlock, approach, lock, stay energised
// - Mode 61 grips without unlocking
// - Modes 63, 64 hold with part-loss test
// - Mode 65 grips at reduced speed
// - Part-loss modes stay energised, flag location
module gripper_mode_sequencer #(
   parameter logic [15:0] MAX_JAW_POS = gripper_pkg::MAX_JAW_POS_DEF
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Motor feedback pins
   input wire logic step_tick,
   input wire logic part_contact,
   input wire logic jaw_blocked,
   // Drive command and position
   output gripper_pkg::drive_cmd_t drive,
   output logic [15:0] measured_jaw_position
);
   import gripper_pkg::*;

   logic [2:0] pins_s;
   logic tick_prev_q;
   logic step, contact_s, blocked_s;
   logic ph_wr_q;
   logic [7:0] ph_addr_q;
   logic take;
   logic [31:0] hrdata_q, rd_d;
   param_set_t shadow_q, act_q;
   logic go_q, commit;
   seq_state_t state_q;
   logic [15:0] pos_q, target_q, cnt_q, fault_q, fault_d;
   logic dir_in_q, grip_q, loss_q, expect_q, lock_q, homed_q, motor_q;
   drive_cmd_t drive_q;
   logic [7:0] m;
   logic [15:0] c;
   logic [3:0] sub;
   logic force_ok, grip_inner, prepos, pos_mode, move_cmd, motion_mode, known;
   logic skip, is_grip, tgt_in, unl_in, part_loss, reduced, moving, home_done;
   logic ev_home, ev_move, ev_motor_on, grip_mv;
   logic [15:0] tgt;
   logic [7:0] appr;
   logic [1:0] hold_lvl;

   ////////////////////////////////////////////////////////////////////////////
   // Pin feedback

   pin_sync #(.WIDTH(3)) u_sync (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .pin_in({jaw_blocked, part_contact, step_tick}),
      .pin_sync_out(pins_s)
   );
   assign contact_s = pins_s[1];
   assign blocked_s = pins_s[2];
   // One step per rising edge of the encoder tick
   assign step = pins_s[0] & ~tick_prev_q;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         tick_prev_q <= 1'b0;
      end else begin
         tick_prev_q <= pins_s[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states

   assign take = hsel & hready & htrans[1] & (hsize == HSIZE_WORD);
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // Address phase capture
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ph_wr_q <= 1'b0;
         ph_addr_q <= 8'h00;
      end else begin
         ph_wr_q <= take & hwrite & ~|haddr[31:8];
         ph_addr_q <= haddr[7:0];
      end
   end

   // Shadow parameters, written field by field
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         shadow_q <= '0;
      end else if (ph_wr_q) begin
         case (ph_addr_q)
            OFS_MODE: shadow_q.mode <= hwdata[7:0];
            OFS_COMMAND: shadow_q.command <= hwdata[15:0];
            OFS_RECIPE: shadow_q.recipe <= hwdata[7:0];
            OFS_WINDOW: shadow_q.window <= hwdata[15:0];
            OFS_SPEED: shadow_q.speed <= hwdata[7:0];
            OFS_OUTER: shadow_q.outer <= hwdata[15:0];
            OFS_INNER: shadow_q.inner <= hwdata[15:0];
            OFS_EXPECT: shadow_q.expect_loc <= hwdata[15:0];
            OFS_SWITCH: shadow_q.switch_pt <= hwdata[15:0];
            OFS_FORCE: shadow_q.force_sp <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // Atomic commit
   // A half-written set never reaches the sequencer: only the handshake copies it
   assign commit = ph_wr_q & (ph_addr_q == OFS_HANDSHAKE);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         act_q <= '0;
         go_q <= 1'b0;
      end else begin
         go_q <= commit;
         if (commit) begin
            act_q <= shadow_q;
         end
      end
   end

   // Read mux, unmapped reads return zero
   always_comb begin
      rd_d = 32'h00000000;
      if (~|haddr[31:8]) begin
         case (haddr[7:0])
            OFS_MODE: rd_d[7:0] = shadow_q.mode;
            OFS_COMMAND: rd_d[15:0] = shadow_q.command;
            OFS_RECIPE: rd_d[7:0] = shadow_q.recipe;
            OFS_WINDOW: rd_d[15:0] = shadow_q.window;
            OFS_SPEED: rd_d[7:0] = shadow_q.speed;
            OFS_OUTER: rd_d[15:0] = shadow_q.outer;
            OFS_INNER: rd_d[15:0] = shadow_q.inner;
            OFS_EXPECT: rd_d[15:0] = shadow_q.expect_loc;
            OFS_SWITCH: rd_d[15:0] = shadow_q.switch_pt;
            OFS_FORCE: rd_d[7:0] = shadow_q.force_sp;
            OFS_STATUS: begin
               rd_d[ST_MOTOR] = motor_q;
               rd_d[ST_BUSY] = moving;
               rd_d[ST_HOMED] = homed_q;
               rd_d[ST_EXPECT] = expect_q;
               rd_d[ST_LOST] = loss_q;
               rd_d[ST_LOCK] = lock_q;
               rd_d[ST_STATE_LSB+3:ST_STATE_LSB] = state_q;
            end
            OFS_POSITION: rd_d[15:0] = pos_q;
            OFS_FAULT: rd_d[15:0] = fault_q;
            default: ;
         endcase
      end
   end

   // Read data stands through the data phase
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         hrdata_q <= 32'h00000000;
      end else if (take & ~hwrite) begin
         hrdata_q <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode decode

   assign m = act_q.mode;
   assign c = act_q.command;
   always_comb begin
      force_ok = 1'b0;
      grip_inner = 1'b0;
      prepos = 1'b0;
      sub = 4'h0;
      for (int g = 0; g < 4; g++) begin
         if (m >= GRP_BASE[g] && m < GRP_BASE[g] + GRP_SPAN) begin
            sub = 4'(m - GRP_BASE[g]);
            force_ok = GRP_MASK[g][sub];
            grip_inner = (g % 2 == 0);
            prepos = (g >= 2);
         end
      end
   end
   assign pos_mode = (m == MODE_POS_STD) | (m == MODE_POS_FAST);
   assign motion_mode = pos_mode | force_ok;
   assign known = motion_mode | (m == MODE_MOTOR_ON) | (m == MODE_HOME_IN);
   assign move_cmd = (c == CMD_TO_OUTER) | (c == CMD_TO_INNER);
   assign is_grip = force_ok & (c == (grip_inner ? CMD_TO_INNER : CMD_TO_OUTER));
   assign tgt = (c == CMD_TO_OUTER) ? act_q.outer : act_q.inner;
   assign tgt_in = tgt > pos_q;
   // Unlock toward standby
   // Standby is the open side; a block on the way ends the unlock early
   assign unl_in = pos_mode ? 1'b0 : ~grip_inner;
   assign skip = pos_mode ? (m == MODE_POS_FAST) : (is_grip & (sub == SUB_FAST));
   assign part_loss = force_ok & (prepos ? (sub == SUB_STRONG) | (sub == SUB_SOFT)
                                         : (sub == SUB_LOSS) | (sub == SUB_STRONG));
   assign hold_lvl = part_loss ? ((sub == SUB_STRONG) ? HOLD_STRONG : HOLD_STD) : HOLD_OFF;
   assign reduced = force_ok & ~prepos & (sub == SUB_SOFT);
   always_comb begin
      appr = {1'b0, act_q.force_sp[7:1]} + APPROACH_BASE;
      if (appr > SPEED_MAX) begin
         appr = SPEED_MAX;
      end
      if (reduced) begin
         appr = {1'b0, appr[7:1]};
      end
   end

   // Events of a committed set
   // Motor on command
   assign ev_motor_on = go_q & (m == MODE_MOTOR_ON) & (c == CMD_ONE);
   assign ev_home = go_q & (m == MODE_HOME_IN) & (c == CMD_ONE) & (act_q.inner <= MAX_JAW_POS);
   assign ev_move = go_q & motion_mode & move_cmd & motor_q;

   assign moving = (state_q != ST_IDLE) & (state_q != ST_BUILD) & (state_q != ST_HOLD);
   assign home_done = (state_q == ST_HOME) & (blocked_s | (pos_q >= MAX_JAW_POS));

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         target_q <= POS_RESET;
         cnt_q <= 16'h0000;
         dir_in_q <= 1'b0;
         grip_q <= 1'b0;
         loss_q <= 1'b0;
         expect_q <= 1'b0;
         lock_q <= 1'b0;
         homed_q <= 1'b0;
      end else if (go_q) begin
         expect_q <= 1'b0;
         loss_q <= 1'b0;
         if (ev_home) begin
            state_q <= ST_HOME;
            dir_in_q <= 1'b1;
            homed_q <= 1'b0;
         end else if (ev_move) begin
            lock_q <= 1'b0;
            target_q <= tgt;
            grip_q <= is_grip;
            if (skip) begin
               state_q <= is_grip ? ST_GRIP : ST_MOVE;
               dir_in_q <= tgt_in;
            end else begin
               state_q <= ST_UNLOCK;
               dir_in_q <= unl_in;
               cnt_q <= UNLOCK_STEPS;
            end
         end else if (motion_mode & (c == CMD_NONE)) begin
            state_q <= ST_IDLE;
         end
      end else begin
         unique case (state_q)
            ST_IDLE: ;
            ST_HOME: begin
               if (home_done) begin
                  state_q <= ST_IDLE;
                  homed_q <= 1'b1;
               end
            end
            ST_UNLOCK: begin
               if (blocked_s | (cnt_q == 16'h0000)) begin
                  state_q <= grip_q ? ST_GRIP : ST_MOVE;
                  dir_in_q <= target_q > pos_q;
               end else if (step) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            ST_MOVE, ST_RETURN: begin
               if ((pos_q == target_q) | blocked_s) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_GRIP: begin
               if (contact_s & ~loss_q) begin
                  state_q <= ST_BUILD;
                  cnt_q <= FORCE_BUILD_CYC;
               end else if (pos_q == target_q) begin
                  state_q <= loss_q ? ST_IDLE : ST_OVERSHOOT;
                  cnt_q <= OVERSHOOT_STEPS;
               end
            end
            ST_BUILD: begin
               if (cnt_q == 16'h0000) begin
                  state_q <= ST_HOLD;
                  lock_q <= 1'b1;
                  expect_q <= part_loss;
               end else begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
            ST_HOLD: begin
               if (part_loss & ~contact_s) begin
                  state_q <= ST_GRIP;
                  loss_q <= 1'b1;
                  expect_q <= 1'b0;
                  lock_q <= 1'b0;
               end
            end
            ST_OVERSHOOT: begin
               if (blocked_s | (cnt_q == 16'h0000)) begin
                  state_q <= ST_RETURN;
                  dir_in_q <= ~dir_in_q;
               end else if (step) begin
                  cnt_q <= cnt_q - 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pos_q <= POS_RESET;
      end else if (home_done) begin
         pos_q <= act_q.inner;
      end else if (step & moving) begin
         pos_q <= dir_in_q ? pos_q + 16'h0001 : pos_q - 16'h0001;
      end
   end
   assign measured_jaw_position = pos_q;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         motor_q <= 1'b0;
      end else if (ev_motor_on | ev_home) begin
         motor_q <= 1'b1;
      end else if (home_done) begin
         motor_q <= 1'b0;
      end
   end

   // Fault classification of a committed set
   always_comb begin
      fault_d = FAULT_NONE;
      if (!known) begin
         fault_d = FAULT_BAD_MODE;
      end else if ((c != CMD_NONE) & (motion_mode ? ~move_cmd : (c != CMD_ONE))) begin
         fault_d = FAULT_BAD_CMD;
      end else if ((m == MODE_HOME_IN) & (c == CMD_ONE) & (act_q.inner > MAX_JAW_POS)) begin
         fault_d = FAULT_PARAM;
      end else if (motion_mode & move_cmd & ~motor_q) begin
         fault_d = FAULT_NOT_READY;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         fault_q <= FAULT_NONE;
      end else if (go_q) begin
         fault_q <= fault_d;
      end else if (home_done) begin
         fault_q <= FAULT_NONE;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drive command

   // Travel under force control
   assign grip_mv = (state_q == ST_GRIP) | (state_q == ST_OVERSHOOT);
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         drive_q <= '0;
      end else begin
         drive_q.enable <= motor_q;
         drive_q.run <= moving;
         drive_q.inward <= dir_in_q;
         drive_q.speed <= grip_mv ? appr : act_q.speed;
         drive_q.force_ctrl <= grip_mv | (state_q == ST_BUILD) | (state_q == ST_HOLD);
         drive_q.hold <= (state_q == ST_BUILD) ? HOLD_BUILD : (state_q == ST_HOLD) ? hold_lvl : HOLD_OFF;
         drive_q.lock <= lock_q;
      end
   end
   assign drive = drive_q;
endmodule

//--- include/gripper_pkg.sv
// Package: registers, codes, types and timing of the sequencer
package gripper_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_COMMAND = 8'h04;
   localparam logic [7:0] OFS_RECIPE = 8'h08;
   localparam logic [7:0] OFS_WINDOW = 8'h0C;
   localparam logic [7:0] OFS_SPEED = 8'h10;
   localparam logic [7:0] OFS_OUTER = 8'h14;
   localparam logic [7:0] OFS_INNER = 8'h18;
   localparam logic [7:0] OFS_EXPECT = 8'h1C;
   localparam logic [7:0] OFS_SWITCH = 8'h20;
   localparam logic [7:0] OFS_FORCE = 8'h24;
   localparam logic [7:0] OFS_HANDSHAKE = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;
   localparam logic [7:0] OFS_POSITION = 8'h30;
   localparam logic [7:0] OFS_FAULT = 8'h34;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   // Status word bit positions
   localparam int ST_MOTOR = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_HOMED = 2;
   localparam int ST_EXPECT = 3;
   localparam int ST_LOST = 4;
   localparam int ST_LOCK = 5;
   localparam int ST_STATE_LSB = 8;
   // Mode codes
   localparam logic [7:0] MODE_MOTOR_ON = 8'h03;
   localparam logic [7:0] MODE_HOME_IN = 8'h11;
   localparam logic [7:0] MODE_POS_STD = 8'h32;
   localparam logic [7:0] MODE_POS_FAST = 8'h33;
   localparam logic [7:0] GRP_SPAN = 8'h0A;
   // Gripping groups 60, 70, 80, 90 and their legal low digits
   localparam logic [7:0] GRP_BASE [0:3] = '{8'h3C, 8'h46, 8'h50, 8'h5A};
   localparam logic [9:0] GRP_MASK [0:3] = '{10'h03B, 10'h03B, 10'h033, 10'h033};
   localparam logic [3:0] SUB_FAST = 4'h1;
   localparam logic [3:0] SUB_LOSS = 4'h3;
   localparam logic [3:0] SUB_STRONG = 4'h4;
   localparam logic [3:0] SUB_SOFT = 4'h5;
   // Command words
   localparam logic [15:0] CMD_NONE = 16'h0000;
   localparam logic [15:0] CMD_ONE = 16'h0001;
   localparam logic [15:0] CMD_TO_OUTER = 16'h0100;
   localparam logic [15:0] CMD_TO_INNER = 16'h0200;
   // Fault codes
   localparam logic [15:0] FAULT_NONE = 16'h0000;
   localparam logic [15:0] FAULT_BAD_MODE = 16'h0101;
   localparam logic [15:0] FAULT_BAD_CMD = 16'h0102;
   localparam logic [15:0] FAULT_PARAM = 16'h0103;
   localparam logic [15:0] FAULT_NOT_READY = 16'h0104;
   // Hold current levels
   localparam logic [1:0] HOLD_OFF = 2'h0;
   localparam logic [1:0] HOLD_STD = 2'h1;
   localparam logic [1:0] HOLD_STRONG = 2'h2;
   localparam logic [1:0] HOLD_BUILD = 2'h3;
   // Motion figures
   localparam logic [15:0] MAX_JAW_POS_DEF = 16'h1000;
   localparam logic [15:0] UNLOCK_STEPS = 16'h0020;
   localparam logic [15:0] OVERSHOOT_STEPS = 16'h0010;
   localparam logic [7:0] APPROACH_BASE = 8'h0A;
   localparam logic [7:0] SPEED_MAX = 8'h64;
   // Timing
   localparam int CLK_PERIOD_NS = 5;
   localparam int FORCE_BUILD_NS = 2000;
   localparam logic [15:0] FORCE_BUILD_CYC = 16'((FORCE_BUILD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // Reset values
   localparam logic [15:0] POS_RESET = 16'h0000;
   // Parameter set latched by the handshake
   typedef struct packed {
      logic [7:0] mode;
      logic [15:0] command;
      logic [7:0] recipe;
      logic [15:0] window;
      logic [7:0] speed;
      logic [15:0] outer;
      logic [15:0] inner;
      logic [15:0] expect_loc;
      logic [15:0] switch_pt;
      logic [7:0] force_sp;
   } param_set_t;
   // Command toward the motor power stage
   typedef struct packed {
      logic enable;
      logic run;
      logic inward;
      logic [7:0] speed;
      logic force_ctrl;
      logic [1:0] hold;
      logic lock;
   } drive_cmd_t;
   typedef enum logic [3:0] {
      ST_IDLE, ST_HOME, ST_UNLOCK, ST_MOVE, ST_GRIP, ST_BUILD, ST_HOLD, ST_OVERSHOOT, ST_RETURN
   } seq_state_t;
endpackage

//--- hdl/pin_sync.sv
// Two-flop synchroniser for asynchronous feedback pins
module pin_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Pins and synchronised levels
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync_out
);
   logic [WIDTH-1:0] meta_q;
   // First stage feeds only the second
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         pin_sync_out <= '0;
      end else begin
         meta_q <= pin_in;
         pin_sync_out <= meta_q;
      end
   end
endmodule

//--- tb/grip_properties.sv
// Checker: port timing relations of the gripper sequencer
module grip_properties
   import gripper_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Drive side
   input wire drive_cmd_t drive,
   input wire logic [15:0] measured_jaw_position
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] build_q;
   wire logic [15:0] p = measured_jaw_position;
   wire logic building = drive.hold == HOLD_BUILD;
   wire logic pos_rd = hsel && hready && htrans[1] && !hwrite && hsize == HSIZE_WORD && haddr == {24'h0, OFS_POSITION};
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // Cycles spent building force
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) build_q <= 16'h0000;
      else build_q <= building ? build_q + 16'h0001 : 16'h0000;
   end
   sequence build_done;
      building ##1 !building;
   endsequence
   a_run_needs_motor: assert property (drive.run |-> drive.enable) else $error("run without motor");
   a_speed_capped: assert property (drive.run |-> drive.speed <= SPEED_MAX) else $error("speed cap");
   a_build_still: assert property (building |-> !drive.run) else $error("moving in build");
   a_build_length: assert property (build_done |-> build_q >= FORCE_BUILD_CYC - 16'h0002
      && build_q <= FORCE_BUILD_CYC + 16'h0002) else $error("build time wrong");
   a_build_locks: assert property (build_done |-> drive.lock) else $error("no lock after build");
   a_load_stops: assert property ($changed(p) && p != $past(p) + 16'h0001 && p != $past(p) - 16'h0001
      |-> ##[0:3] !drive.enable) else $error("jump without stop");
   // Bus answers at once with OKAY
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready");
   // Position read carries the count
   a_pos_read: assert property (pos_rd |=> hrdata == {16'h0000, $past(p)}) else $error("position read");
endmodule
bind gripper_mode_sequencer grip_properties chk (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .drive(drive), .measured_jaw_position(measured_jaw_position));

//--- tb/jaw_model.sv
// Jaw model: steps while driven, halts at a stop or a part
module jaw_model
   import gripper_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Drive and scene
   input wire drive_cmd_t drive,
   input wire logic [15:0] stop_hi,
   input wire logic [15:0] part_pos,
   input wire logic part_en,
   // Feedback pins
   output logic step_tick,
   output logic part_contact,
   output logic jaw_blocked
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] pos_q = 16'h0000;
   logic [2:0] div_q = 3'h0;
   assign jaw_blocked = drive.run && (drive.inward ? pos_q >= stop_hi || part_en && pos_q >= part_pos : pos_q == 16'h0);
   assign part_contact = part_en && pos_q >= part_pos;
   // Slow steps so the sequencer stops before a stray extra step
   always @(posedge sys_clk) begin
      div_q <= drive.run && !jaw_blocked ? div_q + 3'h1 : 3'h0;
      step_tick <= div_q == 3'h7;
      if (div_q == 3'h7) pos_q <= drive.inward ? pos_q + 16'h0001 : pos_q - 16'h0001;
   end
endmodule

//--- tb/tb_top.sv
// Testbench: homing, mode map, positioning and gripping
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import gripper_pkg::*;
   logic sys_clk = 0, resetn = 0, hsel = 0, hwrite = 0, part_en = 0;
   logic [31:0] haddr = 0, hwdata = 0, rv;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [15:0] stop_hi = 16'h0038, part_pos = 16'h0048;
   logic [7:0] grip_spd;
   wire logic rdy, hresp, tick, contact, blocked;
   wire logic [31:0] hrdata;
   wire logic [15:0] pos;
   wire drive_cmd_t drive;
   int bad_count = 0, n_compared = 0;
   gripper_mode_sequencer #(.MAX_JAW_POS(16'h0800)) uut (.sys_clk(sys_clk), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy),
      .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata), .step_tick(tick), .part_contact(contact),
      .jaw_blocked(blocked), .drive(drive), .measured_jaw_position(pos));
   jaw_model jaw (.sys_clk(sys_clk), .drive(drive), .stop_hi(stop_hi), .part_pos(part_pos), .part_en(part_en),
      .step_tick(tick), .part_contact(contact), .jaw_blocked(blocked));
   initial forever #2.5 sys_clk = ~sys_clk;
   // Last approach speed seen under force control
   always @(posedge sys_clk) if (drive.run === 1'b1 && drive.force_ctrl === 1'b1) grip_spd <= drive.speed;
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic phase();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (rdy !== 1'b1 && n < 64);
      if (rdy !== 1'b1) begin
         bad_count++;
         summarize();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= HSIZE_WORD;
      phase();
      htrans <= 2'h0;
      hwdata <= d;
      phase();
      rv = hrdata;
   endtask
   // Commit mode and command, then read the fault word
   task automatic hs(input logic [7:0] m, input logic [15:0] c);
      bus(1'b1, OFS_MODE, {24'h0, m});
      bus(1'b1, OFS_COMMAND, {16'h0, c});
      bus(1'b1, OFS_HANDSHAKE, 32'h0);
      repeat (3) @(posedge sys_clk);
      bus(1'b0, OFS_FAULT, 32'h0);
   endtask
   task automatic wait_st(input logic [3:0] s);
      int n;
      n = 0;
      do begin
         bus(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (rv[11:8] !== s && n < 2000);
      if (rv[11:8] !== s) begin
         bad_count++;
         summarize();
      end
   endtask
   task automatic t_reset();
      bus(1'b0, OFS_POSITION, 32'h0);
      chk("position", 32'h0, rv);
      bus(1'b0, 8'hFC, 32'h0);
      chk("unmapped", 32'h0, rv);
      $display("t_reset done");
   endtask
   task automatic t_home();
      bus(1'b1, OFS_INNER, 32'h900);
      bus(1'b1, OFS_SPEED, 32'hA);
      hs(MODE_HOME_IN, CMD_ONE);
      chk("fault", {16'h0, FAULT_PARAM}, rv);
      bus(1'b1, OFS_INNER, 32'h40);
      hs(MODE_HOME_IN, CMD_ONE);
      wait_st(4'h0);
      chk("position", 32'h40, {16'h0, pos});
      chk("motor", 32'h0, {31'h0, drive.enable});
      bus(1'b0, OFS_FAULT, 32'h0);
      chk("fault", 32'h0, rv);
      hs(MODE_POS_STD, CMD_TO_OUTER);
      chk("fault", {16'h0, FAULT_NOT_READY}, rv);
      hs(MODE_MOTOR_ON, CMD_ONE);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("motor", 32'h1, {31'h0, rv[ST_MOTOR]});
      stop_hi <= 16'h0FFF;
      $display("t_home done");
   endtask
   task automatic t_modes();
      logic [7:0] ok [20] = '{8'h32, 8'h33, 8'h3C, 8'h3D, 8'h3F, 8'h40, 8'h41, 8'h46, 8'h47, 8'h49,
         8'h4A, 8'h4B, 8'h50, 8'h51, 8'h54, 8'h55, 8'h5A, 8'h5B, 8'h5E, 8'h5F};
      logic [7:0] no [6] = '{8'h02, 8'h34, 8'h3E, 8'h48, 8'h52, 8'h64};
      bus(1'b1, OFS_MODE, {24'h0, MODE_POS_FAST});
      bus(1'b1, OFS_COMMAND, {16'h0, CMD_TO_OUTER});
      repeat (6) @(posedge sys_clk);
      chk("run", 32'h0, {31'h0, drive.run});
      foreach (ok[i]) begin
         hs(ok[i], CMD_NONE);
         chk("fault", 32'h0, rv);
      end
      foreach (no[i]) begin
         hs(no[i], CMD_NONE);
         chk("fault", {16'h0, FAULT_BAD_MODE}, rv);
      end
      $display("t_modes done");
   endtask
   task automatic t_position();
      bus(1'b1, OFS_OUTER, 32'h30);
      bus(1'b1, OFS_INNER, 32'h60);
      bus(1'b1, OFS_SPEED, 32'h32);
      bus(1'b1, OFS_EXPECT, 32'h45);
      bus(1'b1, OFS_SWITCH, 32'h50);
      hs(MODE_POS_FAST, CMD_TO_OUTER);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("state", 32'h3, {28'h0, rv[11:8]});
      wait_st(4'h0);
      chk("position", 32'h30, {16'h0, pos});
      part_en <= 1'b1;
      hs(MODE_POS_STD, CMD_TO_INNER);
      wait_st(4'h0);
      chk("position", 32'h50, {16'h0, pos});
      hs(MODE_POS_STD, CMD_TO_OUTER);
      wait_st(4'h0);
      chk("position", 32'h30, {16'h0, pos});
      $display("t_position done");
   endtask
   task automatic t_grip();
      bus(1'b1, OFS_INNER, 32'h80);
      bus(1'b1, OFS_FORCE, 32'h50);
      part_pos <= 16'h0068;
      hs(8'h3F, CMD_TO_INNER);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("state", 32'h2, {28'h0, rv[11:8]});
      wait_st(4'h6);
      chk("position", 32'h70, {16'h0, pos});
      chk("approach", 32'h32, {24'h0, grip_spd});
      chk("hold", {30'h0, HOLD_STD}, {30'h0, drive.hold});
      chk("lock", 32'h1, {31'h0, drive.lock});
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("expect", 32'h3, {30'h0, rv[ST_EXPECT], rv[ST_MOTOR]});
      $display("t_grip done");
   endtask
   task automatic t_nopart();
      part_en <= 1'b0;
      hs(8'h3D, CMD_TO_INNER);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("state", 32'h4, {28'h0, rv[11:8]});
      wait_st(4'h0);
      chk("position", 32'h80, {16'h0, pos});
      hs(8'h3D, CMD_TO_OUTER);
      wait_st(4'h0);
      chk("position", 32'h30, {16'h0, pos});
      hs(8'h47, CMD_TO_INNER);
      wait_st(4'h0);
      hs(8'h47, CMD_TO_OUTER);
      wait_st(4'h0);
      chk("position", 32'h30, {16'h0, pos});
      $display("t_nopart done");
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      t_reset();
      t_home();
      t_modes();
      t_position();
      t_grip();
      t_nopart();
      summarize();
   end
endmodule
